// File: shared/pmc_pkg.sv
`default_nettype none
package pmc_pkg;
  // bus and history widths
  localparam int DW = 8;
  localparam int AW = 16;
  localparam int OW = 5;
  localparam int NUM_UER = 21;
  localparam int NUM_BANKS = 8;
  localparam logic [OW-1:0] LAST_OWNER = 5'h14;
  localparam logic [OW-1:0] IO_BANK_IDX = 5'h09;
  // reset values
  localparam logic [DW-1:0] STACK_RESET = 8'h00;
  localparam logic [DW-1:0] REG_RESET = 8'h00;
  // mode codes held in the low two bits of the history byte
  localparam logic [1:0] MODE_SYS = 2'h0;
  localparam logic [1:0] MODE_USER = 2'h1;
  localparam int DUAL_EN_BIT = 0;
  // register addresses
  localparam logic [AW-1:0] DUAL_MODE_ENABLE_ADDR = 16'h0420;
  localparam logic [AW-1:0] UER_ADDR [NUM_UER] = '{
    16'h0300, 16'h0320, 16'h0330, 16'h0338, 16'h0340, 16'h0348,
    16'h0350, 16'h0360, 16'h0370, 16'h0380, 16'h0388, 16'h0390,
    16'h0398, 16'h03A0, 16'h03B0, 16'h03C0, 16'h03C8, 16'h03D0,
    16'h03D8, 16'h03E0, 16'h03F0};
  // protected address ranges
  localparam logic [AW-1:0] SYS_REG_LAST = 16'h001F;
  localparam logic [7:0] UER_PAGE = 8'h03;
  localparam logic [7:0] MPROT_PAGE = 8'h04;
  // opcode lengths in clocks
  localparam logic [3:0] CYC_SET_USER = 4'h4;
  localparam logic [3:0] CYC_PUSH = 4'h9;
  localparam logic [3:0] CYC_POP = 4'h7;
  localparam logic [3:0] CYC_RESTORE = 4'h4;
  localparam logic [3:0] CYC_TRAP = 4'h2;
  localparam logic [3:0] CYC_READ = 4'h4;
  localparam logic [3:0] CYC_SYSTEM_CALL_OP = 4'hA;
  // interrupt levels
  localparam logic [1:0] VIOLATION_LEVEL = 2'h3;
  localparam logic [1:0] TOP_LEVEL = 2'h3;
  localparam logic [1:0] DEMOTED_LEVEL = 2'h2;
  localparam logic [AW-1:0] SP_STEP = 16'h0001;
  localparam logic [AW-1:0] SP_CALL_STEP = 16'h0002;

  typedef enum logic [2:0] {
    OP_SET_USER = 3'b000,
    OP_PUSH = 3'b001,
    OP_POP = 3'b010,
    OP_RESTORE = 3'b011,
    OP_TRAP = 3'b100,
    OP_READ = 3'b101,
    OP_SYSTEM_CALL_OP = 3'b110
  } pmc_op_e;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_BUSY = 1'b1
  } pmc_state_e;
endpackage : pmc_pkg
`default_nettype wire

// File: logic/pmc_mode_stack.sv
`timescale 1ns/100ps
`default_nettype none
module pmc_mode_stack (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // update requests, one per cycle
  input wire logic setUser,
  input wire logic restore,
  input wire logic enterSys,
  input wire logic load,
  input wire logic [pmc_pkg::DW-1:0] loadData,
  // current history byte
  output logic [pmc_pkg::DW-1:0] modeStack
);
  import pmc_pkg::*;

  // low two bits are the present mode, older modes sit above
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      modeStack <= STACK_RESET;
    end else if (load) begin
      modeStack <= loadData;
    end else if (setUser) begin
      modeStack <= {modeStack[5:0], MODE_USER};
    end else if (enterSys) begin
      modeStack <= {modeStack[5:0], MODE_SYS};
    end else if (restore) begin
      modeStack <= {modeStack[1:0], modeStack[7:2]};
    end
  end
endmodule : pmc_mode_stack
`default_nettype wire

// File: logic/pmc_privilege_mode_control.sv
// Contract
// - Entry to restricted mode, interrupts, restarts and system calls push the mode; the code has no restart opcode, and reset clears the history to 00.
// - Enter-user shifts history left two, sets 01; four clocks.
// - Restore-mode rotates history right two bits, previous mode becomes current.
// - Push-mode stores history at SP-1 in nine clocks; pop loads, SP+1, seven.
// - Read-mode copies history bit zero to carry, no other flag touched.
// - Trap opcode copies E to E when dual mode off or full access.
// - Trap with dual mode on and restricted mode sets the violation flag.
// - With alternate-destination prefix the trap always copies E to alternate E.
// - System call enters full access, SP minus two, jumps to vector; ten clocks.
// - Write-only dual-mode enable register at 0x0420, reset zero.
// - Access enables reset zero; restricted peripheral writes dropped until enabled.
// - Restricted writes to registers of no enabled peripheral are discarded.
// - Disabled bank: drop restricted control writes and suppress its strobe.
// - Restricted access denied to 0000h-001Fh, enable and protection registers.
// - Access enables decode at their listed addresses and are write-only.
// - The trap violation is requested at priority level three.
// - Restricted-mode interrupts programmed at level three are demoted to two.
`timescale 1ns/100ps
`default_nettype none
module pmc_privilege_mode_control (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // opcode request from the execution unit
  input wire logic opStart,
  input wire pmc_pkg::pmc_op_e opCode,
  input wire logic altDest,
  input wire logic intEntry,
  output logic opBusy,
  output logic opDone,
  // stack pointer and vector inputs
  input wire logic [pmc_pkg::AW-1:0] spIn,
  input wire logic [pmc_pkg::DW-1:0] tableBase,
  input wire logic [pmc_pkg::DW-1:0] callOffset,
  // memory access for push and pop
  output logic memWe,
  output logic memRe,
  output logic [pmc_pkg::AW-1:0] memAddr,
  output logic [pmc_pkg::DW-1:0] memWrData,
  input wire logic [pmc_pkg::DW-1:0] memRdData,
  // register and flag effects
  output logic spLoad,
  output logic [pmc_pkg::AW-1:0] spOut,
  output logic pcLoad,
  output logic [pmc_pkg::AW-1:0] pcOut,
  output logic carryLoad,
  output logic carryFlag,
  output logic copyE,
  output logic copyEAlt,
  // violation request
  output logic violationReq,
  output logic [1:0] violationLevel,
  // peripheral interrupt level demotion
  input wire logic userIntReq,
  input wire logic [1:0] userIntLevel,
  output logic userIntReqOut,
  output logic [1:0] userIntLevelOut,
  // internal I/O bus write side
  input wire logic ioWr,
  input wire logic [pmc_pkg::AW-1:0] ioAddr,
  input wire logic [pmc_pkg::DW-1:0] ioWrData,
  input wire logic ioOwnerValid,
  input wire logic [pmc_pkg::OW-1:0] ioOwner,
  input wire logic ioBankCtl,
  input wire logic [2:0] ioBank,
  output logic ioWrOut,
  // I/O bank strobes
  input wire logic [pmc_pkg::NUM_BANKS-1:0] bankStrobeIn,
  output logic [pmc_pkg::NUM_BANKS-1:0] bankStrobeOut,
  // mode status
  output logic [pmc_pkg::DW-1:0] modeStack,
  output logic dualModeOn,
  output logic restricted
);
  import pmc_pkg::*;

  pmc_state_e state;
  pmc_op_e curOp;
  logic [3:0] cnt;
  logic accept;
  logic entryTake;
  logic [DW-1:0] dualModeEnable;
  logic [DW-1:0] uer [NUM_UER];
  logic sysWrite;
  logic protAddr;
  logic ownerOk;
  logic userAllowed;

  // opcode length lookup
  function automatic logic [3:0] cycOf(input pmc_op_e op);
    case (op)
      OP_SET_USER: cycOf = CYC_SET_USER;
      OP_PUSH: cycOf = CYC_PUSH;
      OP_POP: cycOf = CYC_POP;
      OP_RESTORE: cycOf = CYC_RESTORE;
      OP_TRAP: cycOf = CYC_TRAP;
      OP_READ: cycOf = CYC_READ;
      OP_SYSTEM_CALL_OP: cycOf = CYC_SYSTEM_CALL_OP;
      default: cycOf = CYC_TRAP;
    endcase
  endfunction : cycOf

  // interrupt entry wins the cycle; requests while busy are refused
  assign entryTake = intEntry && (state == ST_IDLE);
  assign accept = opStart && (state == ST_IDLE) && !intEntry;
  assign opBusy = (state == ST_BUSY);
  assign opDone = (state == ST_BUSY) && (cnt == 4'h1);

  // sequencer holds the opcode for its documented clock count
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      cnt <= 4'h0;
      curOp <= OP_SET_USER;
    end else begin
      case (state)
        ST_IDLE: begin
          if (accept) begin
            state <= ST_BUSY;
            cnt <= cycOf(opCode) - 4'h1;
            curOp <= opCode;
          end
        end
        ST_BUSY: begin
          cnt <= cnt - 4'h1;
          if (cnt == 4'h1) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // history byte updates
  pmc_mode_stack u_stack (
    .clk(clk),
    .rstn(rstn),
    .setUser(accept && opCode == OP_SET_USER),
    .restore(accept && opCode == OP_RESTORE),
    .enterSys(entryTake || (accept && opCode == OP_SYSTEM_CALL_OP)),
    .load(opDone && curOp == OP_POP),
    .loadData(memRdData),
    .modeStack(modeStack)
  );

  assign dualModeOn = dualModeEnable[DUAL_EN_BIT];
  assign restricted = dualModeOn && modeStack[0];

  // one-cycle effects, issued the cycle after the opcode is taken
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      memWe <= 1'b0;
      memRe <= 1'b0;
      memAddr <= '0;
      memWrData <= '0;
      spLoad <= 1'b0;
      spOut <= '0;
      pcLoad <= 1'b0;
      pcOut <= '0;
    end else begin
      memWe <= 1'b0;
      memRe <= 1'b0;
      spLoad <= 1'b0;
      pcLoad <= 1'b0;
      if (accept && opCode == OP_PUSH) begin
        memWe <= 1'b1;
        memAddr <= spIn - SP_STEP;
        memWrData <= modeStack;
        spLoad <= 1'b1;
        spOut <= spIn - SP_STEP;
      end else if (accept && opCode == OP_POP) begin
        memRe <= 1'b1;
        memAddr <= spIn;
        spLoad <= 1'b1;
        spOut <= spIn + SP_STEP;
      end else if (accept && opCode == OP_SYSTEM_CALL_OP) begin
        spLoad <= 1'b1;
        spOut <= spIn - SP_CALL_STEP;
        pcLoad <= 1'b1;
        pcOut <= {tableBase, callOffset};
      end
    end
  end

  // flag and register-copy effects
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      carryLoad <= 1'b0;
      carryFlag <= 1'b0;
      copyE <= 1'b0;
      copyEAlt <= 1'b0;
      violationReq <= 1'b0;
    end else begin
      carryLoad <= 1'b0;
      copyE <= 1'b0;
      copyEAlt <= 1'b0;
      violationReq <= 1'b0;
      if (accept && opCode == OP_READ) begin
        carryLoad <= 1'b1;
        carryFlag <= modeStack[0];
      end
      if (accept && opCode == OP_TRAP) begin
        if (altDest) begin
          copyEAlt <= 1'b1;
        end else begin
          copyE <= 1'b1;
          violationReq <= dualModeOn && modeStack[0];
        end
      end
    end
  end

  assign violationLevel = VIOLATION_LEVEL;

  // level three is reserved for system sources, so cap user requests
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      userIntReqOut <= 1'b0;
      userIntLevelOut <= 2'h0;
    end else begin
      userIntReqOut <= userIntReq;
      userIntLevelOut <= (userIntLevel == TOP_LEVEL) ? DEMOTED_LEVEL : userIntLevel;
    end
  end

  // enable registers are only writable from full-access code
  assign sysWrite = ioWr && !restricted;

  // dual-mode enable register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dualModeEnable <= REG_RESET;
    end else if (sysWrite && ioAddr == DUAL_MODE_ENABLE_ADDR) begin
      dualModeEnable <= ioWrData;
    end
  end

  // one access-enable register per peripheral
  for (genvar gi = 0; gi < NUM_UER; gi++) begin : g_uer
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        uer[gi] <= REG_RESET;
      end else if (sysWrite && ioAddr == UER_ADDR[gi]) begin
        uer[gi] <= ioWrData;
      end
    end
  end

  assign protAddr = (ioAddr <= SYS_REG_LAST) || (ioAddr[15:8] == UER_PAGE) ||
                    (ioAddr[15:8] == MPROT_PAGE);

  // owner check; the bank register is handled per bank instead
  always_comb begin
    ownerOk = 1'b0;
    if (ioBankCtl) begin
      ownerOk = uer[IO_BANK_IDX][ioBank];
    end else if (ioOwnerValid && ioOwner <= LAST_OWNER && ioOwner != IO_BANK_IDX) begin
      ownerOk = (uer[ioOwner] != REG_RESET);
    end else begin
      ownerOk = 1'b0;
    end
  end

  assign userAllowed = ownerOk && !protAddr;
  // write strobe gating is combinational so bus timing is unchanged
  assign ioWrOut = ioWr && (!restricted || userAllowed);

  // strobes pass untouched outside restricted mode
  for (genvar gb = 0; gb < NUM_BANKS; gb++) begin : g_bank
    assign bankStrobeOut[gb] = bankStrobeIn[gb] && (!restricted || uer[IO_BANK_IDX][gb]);
  end

  // checks
  property p_set_user;
    @(posedge clk) disable iff (!rstn)
    accept && opCode == OP_SET_USER |=>
      modeStack == {$past(modeStack[5:0]), MODE_USER} ##2 opDone;
  endproperty
  a_set_user: assert property (p_set_user) else $error("enter-user wrong");

  property p_restore;
    @(posedge clk) disable iff (!rstn)
    accept && opCode == OP_RESTORE |=>
      modeStack == {$past(modeStack[1:0]), $past(modeStack[7:2])};
  endproperty
  a_restore: assert property (p_restore) else $error("restore wrong");

  property p_entry;
    @(posedge clk) disable iff (!rstn)
    entryTake |=> modeStack == {$past(modeStack[5:0]), MODE_SYS} && !restricted;
  endproperty
  a_entry: assert property (p_entry) else $error("entry push wrong");

  property p_push;
    @(posedge clk) disable iff (!rstn)
    accept && opCode == OP_PUSH |=>
      memWe && memAddr == $past(spIn) - SP_STEP && memWrData == $past(modeStack)
      ##7 opDone;
  endproperty
  a_push: assert property (p_push) else $error("push wrong");

  property p_pop;
    @(posedge clk) disable iff (!rstn)
    accept && opCode == OP_POP |=> memRe && spOut == $past(spIn) + SP_STEP
      ##4 !opDone ##1 opDone ##1 modeStack == $past(memRdData);
  endproperty
  a_pop: assert property (p_pop) else $error("pop wrong");

  property p_read;
    @(posedge clk) disable iff (!rstn)
    accept && opCode == OP_READ |=> carryLoad && carryFlag == $past(modeStack[0]);
  endproperty
  a_read: assert property (p_read) else $error("read-mode wrong");

  property p_trap;
    @(posedge clk) disable iff (!rstn)
    accept && opCode == OP_TRAP && !altDest |=>
      copyE && violationReq == $past(restricted) && opDone;
  endproperty
  a_trap: assert property (p_trap) else $error("trap wrong");

  property p_trap_alt;
    @(posedge clk) disable iff (!rstn)
    accept && opCode == OP_TRAP && altDest |=> copyEAlt && !copyE && !violationReq;
  endproperty
  a_trap_alt: assert property (p_trap_alt) else $error("alt trap wrong");

  property p_system_call_op;
    @(posedge clk) disable iff (!rstn)
    accept && opCode == OP_SYSTEM_CALL_OP |=> pcLoad && !restricted &&
      pcOut == {$past(tableBase), $past(callOffset)} ##8 opDone;
  endproperty
  a_system_call_op: assert property (p_system_call_op) else $error("system_call_op wrong");

  property p_protect;
    @(posedge clk) disable iff (!rstn)
    restricted && protAddr |-> !ioWrOut;
  endproperty
  a_protect: assert property (p_protect) else $error("protected write passed");

  property p_enable_hold;
    @(posedge clk) disable iff (!rstn)
    restricted |=> dualModeEnable == $past(dualModeEnable);
  endproperty
  a_enable_hold: assert property (p_enable_hold) else $error("enable changed");

  property p_strobe;
    @(posedge clk) disable iff (!rstn)
    restricted && !uer[IO_BANK_IDX][0] |-> !bankStrobeOut[0];
  endproperty
  a_strobe: assert property (p_strobe) else $error("bank strobe leaked");

  property p_demote;
    @(posedge clk) disable iff (!rstn)
    userIntLevel == TOP_LEVEL |=> userIntLevelOut == DEMOTED_LEVEL;
  endproperty
  a_demote: assert property (p_demote) else $error("level not demoted");

  c_violation: cover property (@(posedge clk) disable iff (!rstn)
    violationReq);
  c_system_call_op: cover property (@(posedge clk) disable iff (!rstn)
    restricted ##1 accept && opCode == OP_SYSTEM_CALL_OP);
  c_user_write: cover property (@(posedge clk) disable iff (!rstn)
    restricted && ioWrOut);
  c_pop: cover property (@(posedge clk) disable iff (!rstn)
    opDone && curOp == OP_POP);
endmodule : pmc_privilege_mode_control
`default_nettype wire

// File: bench/pmc_exec_model.sv
`timescale 1ns/100ps
`default_nettype none
module pmc_exec_model (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // push and pop memory side
  input wire logic memWe,
  input wire logic memRe,
  input wire logic [pmc_pkg::AW-1:0] memAddr,
  input wire logic [pmc_pkg::DW-1:0] memWrData,
  output logic [pmc_pkg::DW-1:0] memRdData
);
  import pmc_pkg::*;
  // only the low address byte is kept, enough for a short stack window
  logic [DW-1:0] stackMem [256];
  logic [3:0] readLeft;
  logic [DW-1:0] junk;
  // stack bytes land on the write pulse
  always_ff @(posedge clk) begin
    if (memWe) begin
      stackMem[memAddr[7:0]] <= memWrData;
    end
  end
  // read data is held for one pop only, then the bus toggles
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      readLeft <= 4'h0;
      junk <= 8'h5A;
    end else begin
      junk <= ~junk;
      if (memRe) begin
        readLeft <= CYC_POP;
      end else if (readLeft != 4'h0) begin
        readLeft <= readLeft - 4'h1;
      end
    end
  end
  // a stale value would hide a late sample, so outside the window show noise
  assign memRdData = (readLeft != 4'h0) ? stackMem[memAddr[7:0]] : junk;
endmodule : pmc_exec_model
`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import pmc_pkg::*;
  // one row of the restricted I/O gating table
  typedef struct packed {
    logic [AW-1:0] addr;
    logic ov;
    logic [OW-1:0] own;
    logic bc;
    logic [2:0] bk;
    logic expPre;
    logic expPost;
  } pmc_row_s;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic opStart = 1'b0, altDest = 1'b0, intEntry = 1'b0, ioWr = 1'b0;
  logic ioOwnerValid = 1'b0, ioBankCtl = 1'b0, userIntReq = 1'b0;
  pmc_op_e opCode = OP_READ;
  logic [AW-1:0] spIn = 16'h0000, ioAddr = 16'h0000, memAddr, spOut, pcOut;
  logic [DW-1:0] tableBase = 8'h00, callOffset = 8'h00, ioWrData = 8'h00;
  logic [DW-1:0] memWrData, memRdData, modeStack;
  logic [OW-1:0] ioOwner = 5'h00;
  logic [2:0] ioBank = 3'h0;
  logic [1:0] userIntLevel = 2'h0, violationLevel, userIntLevelOut;
  logic [NUM_BANKS-1:0] bankStrobeIn = 8'hFF, bankStrobeOut;
  logic opBusy, opDone, memWe, memRe, spLoad, pcLoad, carryLoad, carryFlag;
  logic copyE, copyEAlt, violationReq, userIntReqOut, ioWrOut, dualModeOn, restricted;
  logic [7:0] pulses;
  int n_fail = 0;
  int cmp_count = 0;
  pmc_row_s rows [11];

  always #5 clk = ~clk;

  pmc_privilege_mode_control dut_u (.clk, .rstn, .opStart, .opCode, .altDest, .intEntry,
    .opBusy, .opDone, .spIn, .tableBase, .callOffset, .memWe, .memRe, .memAddr,
    .memWrData, .memRdData, .spLoad, .spOut, .pcLoad, .pcOut, .carryLoad, .carryFlag,
    .copyE, .copyEAlt, .violationReq, .violationLevel, .userIntReq, .userIntLevel,
    .userIntReqOut, .userIntLevelOut, .ioWr, .ioAddr, .ioWrData, .ioOwnerValid, .ioOwner,
    .ioBankCtl, .ioBank, .ioWrOut, .bankStrobeIn, .bankStrobeOut, .modeStack, .dualModeOn,
    .restricted);

  pmc_exec_model model_u (.clk, .rstn, .memWe, .memRe, .memAddr, .memWrData, .memRdData);

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // issue one opcode, catch the cycle-one pulses and count clocks to done
  task automatic run_op(input pmc_op_e op, input logic alt, input logic [7:0] expP, input int n);
    int cnt;
    @(posedge clk);
    opStart <= 1'b1;
    opCode <= op;
    altDest <= alt;
    @(posedge clk);
    opStart <= 1'b0;
    altDest <= 1'b0;
    #1;
    pulses = {memWe, memRe, spLoad, pcLoad, carryLoad, copyE, copyEAlt, violationReq};
    chk(opBusy, 1'b1);
    cnt = 1;
    while (opDone !== 1'b1 && cnt < 20) begin
      @(posedge clk);
      #1;
      cnt++;
    end
    chk(pulses, expP);
    chk(cnt, n - 1);
  endtask : run_op

  task automatic io_wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    ioWr <= 1'b1;
    ioAddr <= a;
    ioWrData <= d;
    ioOwnerValid <= 1'b0;
    ioBankCtl <= 1'b0;
    @(posedge clk);
    ioWr <= 1'b0;
    #1;
  endtask : io_wr

  // every row writes a nonzero byte, so a stored enable would show later
  task automatic run_rows(input logic post);
    foreach (rows[i]) begin
      @(posedge clk);
      ioWr <= 1'b1;
      ioAddr <= rows[i].addr;
      ioWrData <= 8'hA5;
      ioOwnerValid <= rows[i].ov;
      ioOwner <= rows[i].own;
      ioBankCtl <= rows[i].bc;
      ioBank <= rows[i].bk;
      #1;
      chk(ioWrOut, post ? rows[i].expPost : rows[i].expPre);
      chk(bankStrobeOut, post ? 8'h05 : 8'h00);
    end
    @(posedge clk);
    ioWr <= 1'b0;
    #1;
  endtask : run_rows

  // watchdog well beyond the hundred or so cycles of the sequence
  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    end_of_test();
  end

  initial begin
    rows = '{'{16'h0300, 1'b0, 5'h00, 1'b0, 3'h0, 1'b0, 1'b0},
             '{16'h0010, 1'b0, 5'h00, 1'b0, 3'h0, 1'b0, 1'b0},
             '{16'h001F, 1'b0, 5'h00, 1'b0, 3'h0, 1'b0, 1'b0},
             '{16'h0420, 1'b0, 5'h00, 1'b0, 3'h0, 1'b0, 1'b0},
             '{16'h0020, 1'b1, 5'h00, 1'b0, 3'h0, 1'b0, 1'b1},
             '{16'h0040, 1'b1, 5'h01, 1'b0, 3'h0, 1'b0, 1'b0},
             '{16'h0050, 1'b0, 5'h00, 1'b0, 3'h0, 1'b0, 1'b0},
             '{16'h0060, 1'b1, 5'h09, 1'b0, 3'h0, 1'b0, 1'b0},
             '{16'h0070, 1'b0, 5'h00, 1'b1, 3'h0, 1'b0, 1'b1},
             '{16'h0071, 1'b0, 5'h00, 1'b1, 3'h1, 1'b0, 1'b0},
             '{16'h0080, 1'b1, 5'h15, 1'b0, 3'h0, 1'b0, 1'b0}};
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk(modeStack, 8'h00);
    chk(dualModeOn, 1'b0);
    chk(violationLevel, 2'h3);
    run_op(OP_TRAP, 1'b0, 8'h04, 2);
    io_wr(DUAL_MODE_ENABLE_ADDR, 8'h01);
    chk(dualModeOn, 1'b1);
    run_op(OP_TRAP, 1'b0, 8'h04, 2);
    run_op(OP_SET_USER, 1'b0, 8'h00, 4);
    chk(modeStack, 8'h01);
    chk(restricted, 1'b1);
    run_op(OP_READ, 1'b0, 8'h08, 4);
    chk(carryFlag, 1'b1);
    run_op(OP_TRAP, 1'b0, 8'h05, 2);
    chk(violationLevel, 2'h3);
    run_op(OP_TRAP, 1'b1, 8'h02, 2);
    run_rows(1'b0);
    run_op(OP_RESTORE, 1'b0, 8'h00, 4);
    chk(modeStack, 8'h40);
    io_wr(16'h0300, 8'hFF);
    io_wr(16'h0380, 8'h05);
    run_op(OP_SET_USER, 1'b0, 8'h00, 4);
    chk(modeStack, 8'h01);
    run_rows(1'b1);
    @(posedge clk);
    spIn <= 16'h2000;
    run_op(OP_PUSH, 1'b0, 8'hA0, 9);
    chk(memAddr, 16'h1FFF);
    chk(memWrData, 8'h01);
    chk(spOut, 16'h1FFF);
    run_op(OP_SET_USER, 1'b0, 8'h00, 4);
    chk(modeStack, 8'h05);
    @(posedge clk);
    spIn <= 16'h1FFF;
    run_op(OP_POP, 1'b0, 8'h60, 7);
    chk(memAddr, 16'h1FFF);
    chk(spOut, 16'h2000);
    @(posedge clk);
    #1;
    chk(modeStack, 8'h01);
    @(posedge clk);
    spIn <= 16'h2000;
    tableBase <= 8'h12;
    callOffset <= 8'h34;
    run_op(OP_SYSTEM_CALL_OP, 1'b0, 8'h30, 10);
    chk(modeStack, 8'h04);
    chk(spOut, 16'h1FFE);
    chk(pcOut, 16'h1234);
    @(posedge clk);
    intEntry <= 1'b1;
    @(posedge clk);
    intEntry <= 1'b0;
    #1;
    chk(modeStack, 8'h10);
    // entry and opcode in one cycle: entry wins, the opcode is refused
    @(posedge clk);
    intEntry <= 1'b1;
    opStart <= 1'b1;
    opCode <= OP_SET_USER;
    @(posedge clk);
    intEntry <= 1'b0;
    opStart <= 1'b0;
    #1;
    chk(modeStack, 8'h40);
    chk(opBusy, 1'b0);
    // full-access interrupt levels, top level folds down one
    for (int lv = 0; lv < 4; lv++) begin
      @(posedge clk);
      userIntReq <= 1'b1;
      userIntLevel <= lv[1:0];
      @(posedge clk);
      #1;
      chk(userIntLevelOut, (lv == 3) ? 2'h2 : lv[1:0]);
      chk(userIntReqOut, 1'b1);
    end
    end_of_test();
  end
endmodule : tb
`default_nettype wire
